// ===== hw/ptp_slave.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - all timing counted in clock periods
// - busy line high while slave busy
// - without busy, master spaces bytes 24 periods
// - master holds write data until busy high
// - select low pulse strobes read byte taken
// - zero bus state at token handover
// - busy high at least four periods per byte
// - slave drives data only after direction rises
// - slave releases data when direction falls
// - master owns write token after reset
// - length byte then that many data bytes
// - system resets both ends on watchdog; slave watchdog restarts only the slave resync, master not reset
// - resync command then acknowledge after reset
// - slave watchdog restarts resync after timeout
// - master drives select, direction; slave busy
// - zero end marker passes the token
module ptp_slave
    import ptp_pkg::*;
#(
    parameter int WDOG_CYC = WDOG_CYC_DEF // resync timeout in cycles
) (
    input  wire logic       clk,      // system clock
    input  wire logic       reset,    // async reset, high
    ptp_if.slave            lnk,      // parallel link
    input  wire logic       tx_req,   // message waiting
    input  wire logic [7:0] tx_len,   // message length
    input  wire logic [7:0] tx_data,  // current data byte
    output logic            tx_take,  // data byte sent
    output logic [7:0]      rx_data,  // received data byte
    output logic            rx_valid, // rx_data strobe
    output logic            rx_eom,   // message complete
    output logic            synced    // resync done
);
    typedef enum logic [1:0] {
        S_BUSY = 2'b00,
        S_PRES = 2'b01,
        S_IDLE = 2'b11
    } ptp_slv_e;

    ptp_slv_e   state_r;
    ptp_stage_e stg_r;
    logic       tok_r;
    logic       sel_s;
    logic       dir_s;
    logic       sel_q;
    logic [2:0] bcnt_r;
    logic [7:0] cnt_r;
    logic [24:0] wd_r;
    logic       busy_r;
    logic       oe_r;
    logic [7:0] data_r;
    logic       tx_take_r;
    logic       rx_valid_r;
    logic       rx_eom_r;
    logic       synced_r;
    logic [7:0] rx_data_r;

    // select and direction into the clock domain
    ptp_sync #(
        .W   (2),
        .RST ({SEL_IDLE, 1'b0})
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({lnk.select_pin_n, lnk.direction_pin}),
        .q     ({sel_s, dir_s})
    );

    // byte events and selections
    wire logic       take     = (state_r == S_IDLE) && sel_s && !sel_q;
    wire logic [7:0] rb       = lnk.bus;
    wire logic [7:0] lenv     = tok_r ? data_r : rb;
    wire logic       busy_dn  = (bcnt_r == BUSY_CYC - 3'd1);
    wire logic       wd_hit   = !synced_r && (wd_r == 25'(WDOG_CYC - 1));
    wire logic       present  = tok_r || (stg_r == PG_ACK);
    wire logic       drive    = (state_r == S_PRES) && dir_s;
    // the acknowledge strobe hands the token to the master as well
    wire logic       hand_off = take && ((tok_r && (stg_r == PG_EOM)) || (stg_r == PG_ACK));
    wire logic       is_data  = take && (stg_r == PG_DATA);
    wire logic [7:0] sbyte    = (stg_r == PG_ACK)  ? RESYNC_ACKNOWLEDGE :
                                (stg_r == PG_LEN)  ? (tx_req ? tx_len : BUS_IDLE) :
                                (stg_r == PG_DATA) ? tx_data : END_OF_TRANSFER_MARKER;

    // previous select level for the rising edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_q <= SEL_IDLE;
        end else begin
            sel_q <= sel_s;
        end
    end

    // busy line sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= S_BUSY;
            busy_r  <= BUSY_RST;
            bcnt_r  <= 3'h0;
        end else if (wd_hit) begin
            state_r <= S_BUSY;
            busy_r  <= 1'b1;
            bcnt_r  <= 3'h0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (take) begin
                        state_r <= S_BUSY;
                        busy_r  <= 1'b1;
                        bcnt_r  <= 3'h0;
                    end
                end
                S_BUSY: begin
                    bcnt_r <= bcnt_r + 3'h1;
                    if (busy_dn) begin
                        state_r <= present ? S_PRES : S_IDLE;
                        busy_r  <= present;
                    end
                end
                S_PRES: begin
                    if (dir_s) begin
                        state_r <= S_IDLE;
                        busy_r  <= 1'b0;
                    end
                end
                default: begin
                    state_r <= S_BUSY;
                end
            endcase
        end
    end

    // message stage and write token
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stg_r    <= PG_SYNC;
            tok_r    <= 1'b0;
            cnt_r    <= 8'h00;
            synced_r <= 1'b0;
        end else if (wd_hit) begin
            stg_r <= PG_SYNC;
            tok_r <= 1'b0;
        end else if (take) begin
            unique case (stg_r)
                PG_SYNC: begin
                    if (!dir_s && rb == RESYNC_COMMAND) begin
                        stg_r <= PG_ACK;
                    end
                end
                PG_ACK: begin
                    stg_r    <= PG_LEN;
                    tok_r    <= 1'b0;
                    synced_r <= 1'b1;
                end
                PG_LEN: begin
                    cnt_r <= lenv;
                    stg_r <= (lenv == 8'h00) ? PG_EOM : PG_DATA;
                end
                PG_DATA: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        stg_r <= PG_EOM;
                    end
                end
                PG_EOM: begin
                    stg_r <= PG_LEN;
                    tok_r <= !tok_r;
                end
                default: begin
                    stg_r <= PG_SYNC;
                end
            endcase
        end
    end

    // data lines: drive on read, release on write or handover
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_r <= BUS_IDLE;
            oe_r   <= 1'b0;
        end else if (wd_hit || hand_off) begin
            data_r <= BUS_IDLE;
            oe_r   <= 1'b0;
        end else if (drive) begin
            data_r <= sbyte;
            oe_r   <= 1'b1;
        end else if (!dir_s) begin
            data_r <= BUS_IDLE;
            oe_r   <= 1'b0;
        end
    end

    // user side strobes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_take_r  <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_eom_r   <= 1'b0;
            rx_data_r  <= BUS_IDLE;
        end else begin
            tx_take_r  <= is_data && tok_r;
            rx_valid_r <= is_data && !tok_r;
            rx_eom_r   <= take && !tok_r && (stg_r == PG_EOM);
            if (is_data && !tok_r) begin
                rx_data_r <= rb;
            end
        end
    end

    // resync watchdog, runs until synchronised
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_r <= 25'h0000000;
        end else if (synced_r || wd_hit) begin
            wd_r <= 25'h0000000;
        end else begin
            wd_r <= wd_r + 25'h0000001;
        end
    end

    // link and user outputs
    assign lnk.slave_busy_ack = busy_r;
    assign lnk.s_data         = data_r;
    assign lnk.s_oe           = oe_r;
    assign tx_take            = tx_take_r;
    assign rx_data            = rx_data_r;
    assign rx_valid           = rx_valid_r;
    assign rx_eom             = rx_eom_r;
    assign synced             = synced_r;
endmodule : ptp_slave
`default_nettype wire

// ===== hw/ptp_pkg.sv
package ptp_pkg;
    // clock and link timing; clock in ns, link units in clock periods, watchdog in ms
    localparam int         CLK_PERIOD_NS        = 50;
    localparam int         CLOCK_PERIOD_UNIT_NS = CLK_PERIOD_NS;
    localparam int         GAP_UNITS            = 24;
    localparam int         BUSY_UNITS           = 4;
    localparam int         CS_UNITS             = 2;
    localparam int         WDOG_MS              = 840;
    localparam logic [4:0] GAP_CYC  = 5'(GAP_UNITS * CLOCK_PERIOD_UNIT_NS / CLK_PERIOD_NS);
    localparam logic [2:0] BUSY_CYC = 3'(BUSY_UNITS * CLOCK_PERIOD_UNIT_NS / CLK_PERIOD_NS);
    localparam logic [1:0] CS_CYC   = 2'(CS_UNITS * CLOCK_PERIOD_UNIT_NS / CLK_PERIOD_NS);
    localparam int         WDOG_CYC_DEF = WDOG_MS * 1000000 / CLK_PERIOD_NS;

    // protocol bytes
    localparam logic [7:0] RESYNC_COMMAND         = 8'h5a;
    localparam logic [7:0] RESYNC_ACKNOWLEDGE     = 8'h07;
    localparam logic [7:0] END_OF_TRANSFER_MARKER = 8'h00;

    // reset and idle levels
    localparam logic [7:0] BUS_IDLE = 8'h00;
    localparam logic       SEL_IDLE = 1'b1;
    localparam logic       BUSY_RST = 1'b1;

    // position inside the message exchange
    typedef enum logic [2:0] {
        PG_SYNC = 3'b000,
        PG_ACK  = 3'b001,
        PG_LEN  = 3'b011,
        PG_DATA = 3'b010,
        PG_EOM  = 3'b110
    } ptp_stage_e;
endpackage : ptp_pkg

// ===== hw/ptp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ptp_if;
    logic       select_pin_n;   // master select, low active
    logic       direction_pin;  // high: master reads
    logic       slave_busy_ack; // slave busy when high
    logic [7:0] m_data;         // master data out
    logic       m_oe;           // master drives data
    logic [7:0] s_data;         // slave data out
    logic       s_oe;           // slave drives data
    logic [7:0] bus;            // resolved data lines

    // level of the shared data lines, zero when nobody drives
    assign bus = m_oe ? m_data : (s_oe ? s_data : ptp_pkg::BUS_IDLE);

    modport master (
        output select_pin_n,
        output direction_pin,
        output m_data,
        output m_oe,
        input  slave_busy_ack,
        input  bus
    );
    modport slave (
        input  select_pin_n,
        input  direction_pin,
        input  bus,
        output slave_busy_ack,
        output s_data,
        output s_oe
    );
endinterface : ptp_if
`default_nettype wire

// ===== hw/ptp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,   // system clock
    input  wire logic         reset, // async reset
    input  wire logic [W-1:0] d,     // raw levels
    output logic [W-1:0]      q      // synchronised levels
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // two flip-flop chain per bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= RST;
            q_r    <= RST;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end

    assign q = q_r;
endmodule : ptp_sync
`default_nettype wire

// ===== hw/ptp_master.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_master
    import ptp_pkg::*;
(
    input  wire logic       clk,      // system clock
    input  wire logic       reset,    // async reset, high
    ptp_if.master           lnk,      // parallel link
    input  wire logic       tx_req,   // message waiting
    input  wire logic [7:0] tx_len,   // message length
    input  wire logic [7:0] tx_data,  // current data byte
    output logic            tx_take,  // data byte sent
    output logic [7:0]      rx_data,  // received data byte
    output logic            rx_valid, // rx_data strobe
    output logic            rx_eom,   // message complete
    output logic            synced    // resync done
);
    typedef enum logic [1:0] {
        M_WAIT   = 2'b00,
        M_SETUP  = 2'b01,
        M_STROBE = 2'b11,
        M_HOLD   = 2'b10
    } ptp_mst_e;

    ptp_mst_e   state_r;
    ptp_stage_e stg_r;
    logic       wr_r;
    logic [7:0] cnt_r;
    logic [7:0] byte_r;
    logic [7:0] data_r;
    logic [7:0] rx_data_r;
    logic [4:0] gap_r;
    logic [1:0] cs_r;
    logic       sel_n_r;
    logic       dir_r;
    logic       oe_r;
    logic       tx_take_r;
    logic       rx_valid_r;
    logic       rx_eom_r;
    logic       synced_r;

    // byte engine decode
    wire logic       busy   = lnk.slave_busy_ack;
    wire logic       gap_ok = (gap_r >= GAP_CYC);
    wire logic       go     = (state_r == M_SETUP) && gap_ok && !busy;
    wire logic       done   = (state_r == M_HOLD) && (busy || gap_ok);
    wire logic       cs_end = (cs_r == CS_CYC - 2'd1);
    wire logic       ack_ok = (byte_r == RESYNC_ACKNOWLEDGE);
    wire logic [7:0] lenv   = wr_r ? data_r : byte_r;
    wire logic [7:0] wbyte  = (stg_r == PG_SYNC) ? RESYNC_COMMAND :
                              (stg_r == PG_LEN)  ? (tx_req ? tx_len : BUS_IDLE) :
                              (stg_r == PG_DATA) ? tx_data : END_OF_TRANSFER_MARKER;

    // select strobe sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= M_WAIT;
            sel_n_r <= SEL_IDLE;
            cs_r    <= 2'h0;
        end else begin
            unique case (state_r)
                M_WAIT: begin
                    if (!busy) begin
                        state_r <= M_SETUP;
                    end
                end
                M_SETUP: begin
                    if (go) begin
                        state_r <= M_STROBE;
                        sel_n_r <= 1'b0;
                        cs_r    <= 2'h0;
                    end
                end
                M_STROBE: begin
                    cs_r <= cs_r + 2'h1;
                    if (cs_end) begin
                        sel_n_r <= 1'b1;
                        state_r <= M_HOLD;
                    end
                end
                M_HOLD: begin
                    if (done) begin
                        state_r <= M_SETUP;
                    end
                end
            endcase
        end
    end

    // byte spacing, saturating count since last strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gap_r <= 5'h00;
        end else if (go) begin
            gap_r <= 5'h00;
        end else if (!gap_ok) begin
            gap_r <= gap_r + 5'h01;
        end
    end

    // direction and data lines, held through strobe and hold
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dir_r  <= 1'b0;
            oe_r   <= 1'b0;
            data_r <= BUS_IDLE;
            byte_r <= BUS_IDLE;
        end else begin
            if (state_r == M_SETUP) begin
                dir_r  <= !wr_r;
                oe_r   <= wr_r && !dir_r;
                data_r <= wr_r ? wbyte : BUS_IDLE;
            end
            if (go && !wr_r) begin
                byte_r <= lnk.bus;
            end
        end
    end

    // message stage and write token
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stg_r    <= PG_SYNC;
            wr_r     <= 1'b1;
            cnt_r    <= 8'h00;
            synced_r <= 1'b0;
        end else if (done) begin
            unique case (stg_r)
                PG_SYNC: begin
                    stg_r <= PG_ACK;
                    wr_r  <= 1'b0;
                end
                PG_ACK: begin
                    stg_r    <= ack_ok ? PG_LEN : PG_SYNC;
                    wr_r     <= 1'b1;
                    synced_r <= ack_ok;
                end
                PG_LEN: begin
                    cnt_r <= lenv;
                    stg_r <= (lenv == 8'h00) ? PG_EOM : PG_DATA;
                end
                PG_DATA: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        stg_r <= PG_EOM;
                    end
                end
                PG_EOM: begin
                    stg_r <= PG_LEN;
                    wr_r  <= !wr_r;
                end
                default: begin
                    stg_r <= PG_SYNC;
                end
            endcase
        end
    end

    // user side strobes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_take_r  <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_eom_r   <= 1'b0;
            rx_data_r  <= BUS_IDLE;
        end else begin
            tx_take_r  <= done && wr_r && (stg_r == PG_DATA);
            rx_valid_r <= done && !wr_r && (stg_r == PG_DATA);
            rx_eom_r   <= done && !wr_r && (stg_r == PG_EOM);
            if (done && !wr_r && (stg_r == PG_DATA)) begin
                rx_data_r <= byte_r;
            end
        end
    end

    // link and user outputs
    assign lnk.select_pin_n  = sel_n_r;
    assign lnk.direction_pin = dir_r;
    assign lnk.m_data        = data_r;
    assign lnk.m_oe          = oe_r;
    assign tx_take           = tx_take_r;
    assign rx_data           = rx_data_r;
    assign rx_valid          = rx_valid_r;
    assign rx_eom            = rx_eom_r;
    assign synced            = synced_r;
endmodule : ptp_master
`default_nettype wire

// ===== tb/ptp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_properties
    import ptp_pkg::*;
(
    input  wire logic       clk,            // system clock
    input  wire logic       reset,          // async reset, high
    input  wire logic       select_pin_n,   // master select
    input  wire logic       direction_pin,  // high: master reads
    input  wire logic       slave_busy_ack, // slave busy
    input  wire logic [7:0] m_data,         // master data out
    input  wire logic       m_oe,           // master drives data
    input  wire logic [7:0] s_data,         // slave data out
    input  wire logic       s_oe,           // slave drives data
    input  wire logic [7:0] bus             // resolved data lines
);
    logic [4:0] gap_r;   // cycles since last select fall
    logic       first_r; // no strobe finished since reset

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // strobe spacing counter, saturating, and first-strobe flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gap_r   <= 5'h1f;
            first_r <= 1'b1;
        end else begin
            gap_r   <= $fell(select_pin_n) ? 5'h01 : (gap_r == 5'h1f ? gap_r : gap_r + 5'h01);
            first_r <= first_r && !$rose(select_pin_n);
        end
    end

    // link timing and ownership checks
    AST_BUSY_HIGH4: assert property ($rose(slave_busy_ack) |-> slave_busy_ack[*4])
        else $error("busy high shorter than four cycles");
    AST_SEL_IDLE_BUSY: assert property ($fell(select_pin_n) |-> !$past(slave_busy_ack))
        else $error("select fell while slave busy");
    AST_GAP24: assert property ($fell(select_pin_n) |-> gap_r >= GAP_CYC)
        else $error("strobes closer than the byte gap");
    AST_SEL_2CYC: assert property ($fell(select_pin_n) |-> !select_pin_n[*2] ##1 select_pin_n)
        else $error("select pulse not two cycles");
    AST_BUSY_ANSWER: assert property ($rose(select_pin_n) |-> ##[2:5] slave_busy_ack)
        else $error("slave did not answer strobe with busy");
    AST_WRITE_HOLD: assert property ($rose(select_pin_n) && m_oe
        |-> (m_oe && $stable(m_data)) until slave_busy_ack)
        else $error("write data changed before busy");
    AST_SLAVE_DRIVE: assert property ($rose(s_oe) |-> direction_pin && $past(direction_pin, 2))
        else $error("slave drove bus without read direction");
    AST_SLAVE_RELEASE: assert property ($fell(direction_pin) |-> ##[0:4] !s_oe)
        else $error("slave kept bus after write direction");
    AST_NO_CONTENTION: assert property (m_oe |-> !s_oe)
        else $error("both ends drive the data lines");
    AST_RESYNC_FIRST: assert property (first_r && $rose(select_pin_n)
        |-> !direction_pin && bus == RESYNC_COMMAND)
        else $error("first byte after reset not resync command");

    // main traffic kinds
    cover property ($fell(select_pin_n) && !direction_pin);
    cover property ($rose(select_pin_n) && s_oe && bus == s_data);
    cover property ($rose(s_oe));
endmodule : ptp_properties
`default_nettype wire

// ===== tb/parallel_token_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_token_port_bench;
    import ptp_pkg::*;
    localparam int LIM    = 4000; // bound of the send and expect_rx waits
    localparam int WD_LIM = 2000; // slave resync watchdog, cycles
    logic       clk         = 1'b0;
    logic       reset       = 1'b1;
    logic       tx_req  [2] = '{1'b0, 1'b0};
    logic [7:0] tx_len  [2] = '{8'h00, 8'h00};
    logic [7:0] tx_data [2] = '{8'h00, 8'h00};
    logic       tx_take [2];
    logic [7:0] rx_data [2];
    logic       rx_valid[2];
    logic       rx_eom  [2];
    logic       eom_seen[2];
    logic       synced  [2];
    logic [7:0] exp_q   [2][$];
    logic [7:0] rx_q    [2][$];
    time        first_t [2];
    int         n_errors    = 0;
    int         checks_done = 0;
    int         lens  [3]   = '{1, 5, 8};
    logic [7:0] bases [3]   = '{8'h5a, 8'h03, 8'hff};

    // 20 MHz clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    ptp_if lnk ();
    ptp_master u_ptp_master (.clk(clk), .reset(reset), .lnk(lnk.master), .tx_req(tx_req[0]),
        .tx_len(tx_len[0]), .tx_data(tx_data[0]), .tx_take(tx_take[0]), .rx_data(rx_data[0]),
        .rx_valid(rx_valid[0]), .rx_eom(rx_eom[0]), .synced(synced[0]));
    ptp_slave #(.WDOG_CYC(WD_LIM)) u_ptp_slave (.clk(clk), .reset(reset), .lnk(lnk.slave),
        .tx_req(tx_req[1]), .tx_len(tx_len[1]), .tx_data(tx_data[1]), .tx_take(tx_take[1]),
        .rx_data(rx_data[1]), .rx_valid(rx_valid[1]), .rx_eom(rx_eom[1]),
        .synced(synced[1]));
    ptp_properties u_ptp_properties (.clk(clk), .reset(reset), .select_pin_n(lnk.select_pin_n),
        .direction_pin(lnk.direction_pin), .slave_busy_ack(lnk.slave_busy_ack),
        .m_data(lnk.m_data), .m_oe(lnk.m_oe), .s_data(lnk.s_data), .s_oe(lnk.s_oe),
        .bus(lnk.bus));

    // collect received bytes of both user sides
    always @(posedge clk) begin
        for (int s = 0; s < 2; s++) begin
            if (rx_valid[s] === 1'b1) begin
                rx_q[s].push_back(rx_data[s]);
                eom_seen[s] = 1'b0;
                if (first_t[s] == 0)
                    first_t[s] = $time;
            end
            if (rx_eom[s] === 1'b1)
                eom_seen[s] = 1'b1;
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic finish_test();
        $display("checks_done %0d n_errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic timeout();
        n_errors++;
        $display("ERROR %0t: wait bound used up", $time);
        finish_test();
    endtask : timeout

    // reset both ends together, check idle levels, wait for resync
    task automatic do_reset();
        int k;
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        check_bit(lnk.select_pin_n, SEL_IDLE);
        check_bit(lnk.slave_busy_ack, BUSY_RST);
        check_byte(lnk.bus, BUS_IDLE);
        check_bit(synced[1], 1'b0);
        for (int s = 0; s < 2; s++) begin
            rx_q[s].delete();
            exp_q[s].delete();
            first_t[s] = 0;
            eom_seen[s] = 1'b0;
        end
        reset <= 1'b0;
        for (k = 0; k < WD_LIM && !(synced[0] === 1'b1 && synced[1] === 1'b1); k++)
            @(posedge clk);
        if (k == WD_LIM)
            timeout();
    endtask : do_reset

    // side s offers a message of n bytes, byte i = base ^ i
    task automatic send(input int s, input int n, input logic [7:0] base);
        int k;
        tx_len[s]  <= 8'(n);
        tx_data[s] <= base;
        tx_req[s]  <= 1'b1;
        for (int i = 0; i < n; i++) begin
            exp_q[s].push_back(base ^ 8'(i));
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (tx_take[s] !== 1'b1 && k < LIM);
            if (k == LIM)
                timeout();
            tx_data[s] <= base ^ 8'(i + 1);
        end
        tx_req[s] <= 1'b0;
    endtask : send

    // what side s sent must arrive whole at the other side, nothing more
    task automatic expect_rx(input int s);
        int k;
        for (k = 0; k < LIM && rx_q[1-s].size() < exp_q[s].size(); k++)
            @(posedge clk);
        if (k == LIM)
            timeout();
        repeat (300) @(posedge clk);
        check_bit(eom_seen[1-s], 1'b1);
        check_byte(8'(rx_q[1-s].size()), 8'(exp_q[s].size()));
        while (exp_q[s].size() > 0 && rx_q[1-s].size() > 0)
            check_byte(rx_q[1-s].pop_front(), exp_q[s].pop_front());
        exp_q[s].delete();
        rx_q[1-s].delete();
    endtask : expect_rx

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        timeout();
    end

    // main sequence
    initial begin
        do_reset();
        fork
            send(0, 3, 8'h11);
            send(1, 2, 8'ha1);
        join
        expect_rx(0);
        expect_rx(1);
        check_bit(first_t[1] < first_t[0], 1'b1);
        // length boundaries, a zero data byte, resync value as data
        for (int t = 0; t < 3; t++) begin
            fork
                send(0, lens[t], bases[t]);
                send(1, lens[t], ~bases[t]);
            join
            expect_rx(0);
            expect_rx(1);
        end
        // second joint reset in mid-run, then traffic again
        do_reset();
        fork
            send(0, 2, 8'h40);
            send(1, 4, 8'hc3);
        join
        expect_rx(0);
        expect_rx(1);
        check_bit(first_t[1] < first_t[0], 1'b1);
        finish_test();
    end
endmodule : parallel_token_port_bench
`default_nettype wire
